// file: hw/wdog_map.svh
// Register offsets, field positions, reset values and timing counts of the watchdog pair
// Notes on behaviour
// (RULE1) Independent watchdog counts down in 12 bits, advanced by an 8-bit prescaler.
// (RULE2) Independent watchdog runs from its own 32 kHz low-speed tick, not main clock.
// (RULE3) Independent watchdog keeps counting in Stop and Standby low-power modes.
// (RULE4) Independent watchdog can reset the device when software fails to service it.
// (RULE5) Independent watchdog may instead serve as a free-running timeout timer.
// (RULE6) A nonvolatile option chooses hardware auto-start or software-only start.
// (RULE7) Window watchdog counts down in 7 bits and can run freely.
// (RULE8) Window watchdog can reset the device when software services it wrongly.
// (RULE9) Window watchdog is clocked from the main system clock.
// (RULE10) Window watchdog raises an early-warning interrupt before its reset.
// (RULE11) When configured, window counter freezes while the processor halts in debug.
// (RULE12) Independent watchdog resets at zero unless reloaded; reload restarts from reload value.
`ifndef WDOG_MAP_SVH
`define WDOG_MAP_SVH

`define CLK_HZ          50000000
`define LSI_HZ          32000
`define LSI_DIV         (`CLK_HZ / `LSI_HZ)
`define WWDG_DIV        4096

`define OFS_IW_KEY      8'h00
`define OFS_IW_PRESC    8'h04
`define OFS_IW_RELOAD   8'h08
`define OFS_IW_STATUS   8'h0C
`define OFS_IW_CFG      8'h10
`define OFS_WW_CTRL     8'h14
`define OFS_WW_CFG      8'h18
`define OFS_IRQ_STATUS  8'h1C
`define OFS_IRQ_MASK    8'h20

`define KEY_RELOAD      16'hAAAA
`define KEY_START       16'hCCCC

`define RST_IW_PRESC    8'h00
`define RST_IW_RELOAD   12'hFFF
`define RST_WW_CNT      7'h7F
`define RST_WW_WIN      7'h7F

`define WW_ACT_BIT      7
`define WW_FREEZE_BIT   8
`define IW_RUN_BIT      16
`define IW_TIMER_BIT    0
`define IRQ_IW_BIT      0
`define IRQ_WW_BIT      1
`define WW_EARLY_VAL    7'h40

`endif

// file: hw/wdog_pkg.sv
// Types shared by the watchdog pair
package wdog_pkg;
    typedef enum logic [1:0] {
        IW_IDLE = 2'b00,
        IW_RUN  = 2'b01
    } iw_state_t;

    typedef enum logic [1:0] {
        RESP_OKAY   = 2'b00,
        RESP_DECERR = 2'b11
    } axi_resp_t;
endpackage

// file: hw/indep_wdog.sv
// Independent watchdog: 8-bit prescaler feeding a 12-bit downcounter
`timescale 1ns/1ps
`default_nettype none
`include "wdog_map.svh"
module indep_wdog
    import wdog_pkg::*;
#(
    parameter int CNT_W = 12,
    parameter int PRE_W = 8
) (
    // Clock and reset
    input  wire logic             aclk,
    input  wire logic             aresetn,
    // Low-speed tick and controls
    input  wire logic             lsi_tick,
    input  wire logic             hw_start,
    input  wire logic             start_cmd,
    input  wire logic             reload_cmd,
    input  wire logic [PRE_W-1:0] presc,
    input  wire logic [CNT_W-1:0] reload_val,
    // State
    output logic      [CNT_W-1:0] count,
    output logic                  running,
    output logic                  expire
);
    iw_state_t        state_reg;
    logic             boot_reg;
    logic [PRE_W-1:0] pre_reg;
    logic             step;

    // Option strap is looked at in the first cycle after reset release
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            boot_reg <= 1'b1;
        end else begin
            boot_reg <= 1'b0;
        end
    end

    // Once started nothing but a reset stops it
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            state_reg <= IW_IDLE;
        end else begin
            case (state_reg)
                IW_IDLE: begin
                    if (start_cmd || (boot_reg && hw_start)) begin // RULE6
                        state_reg <= IW_RUN;
                    end
                end
                IW_RUN:  state_reg <= IW_RUN;
                default: state_reg <= IW_IDLE;
            endcase
        end
    end

    assign running = (state_reg == IW_RUN);
    assign step    = running && lsi_tick && (pre_reg == presc); // RULE1

    // Prescaler counts low-speed ticks only, so main-clock gating does not stop it
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            pre_reg <= '0;
        end else if (running && lsi_tick) begin // RULE2 RULE3
            pre_reg <= (pre_reg == presc) ? '0 : pre_reg + 1'b1;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            count <= `RST_IW_RELOAD;
        end else if (reload_cmd || (!running && start_cmd)) begin
            count <= reload_val; // RULE12
        end else if (step) begin
            count <= (count == '0) ? reload_val : count - 1'b1; // RULE1 RULE5
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            expire <= 1'b0;
        end else begin
            expire <= step && (count == '0) && !reload_cmd; // RULE12
        end
    end
endmodule
`default_nettype wire

// file: hw/window_wdog.sv
// Window watchdog: 7-bit downcounter with early warning and debug freeze
`timescale 1ns/1ps
`default_nettype none
`include "wdog_map.svh"
module window_wdog #(
    parameter int CNT_W = 7
) (
    // Clock and reset
    input  wire logic             aclk,
    input  wire logic             aresetn,
    // Controls
    input  wire logic             tick,
    input  wire logic             freeze,
    input  wire logic             activate,
    input  wire logic             write_cnt,
    input  wire logic [CNT_W-1:0] wr_val,
    input  wire logic [CNT_W-1:0] window,
    // State
    output logic      [CNT_W-1:0] count,
    output logic                  active,
    output logic                  early,
    output logic                  reset_req
);
    logic dec;
    logic too_early;
    logic underflow;

    assign dec       = tick && !freeze; // RULE11
    assign too_early = write_cnt && active && (count > window);
    assign underflow = dec && (count == `WW_EARLY_VAL);

    // Activation is one-way; counting runs freely whether active or not
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            active <= 1'b0;
        end else if (activate) begin
            active <= 1'b1;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            count <= `RST_WW_CNT;
        end else if (write_cnt) begin
            count <= wr_val;
        end else if (dec) begin
            count <= count - 1'b1; // RULE7 RULE9
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            early     <= 1'b0;
            reset_req <= 1'b0;
        end else begin
            early     <= dec && (count == `WW_EARLY_VAL + 7'h01) && !write_cnt; // RULE10
            reset_req <= active && (too_early || (underflow && !write_cnt)); // RULE8
        end
    end
endmodule
`default_nettype wire

// file: hw/dual_watchdog_timers.sv
// Top of the watchdog pair with its AXI4-Lite register slave and interrupt logic
//
// Chosen here: the register offsets and the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
`default_nettype none
`include "wdog_map.svh"
module dual_watchdog_timers
    import wdog_pkg::*;
#(
    parameter int LSI_DIV  = `LSI_DIV,
    parameter int WWDG_DIV = `WWDG_DIV
) (
    // Clock and reset
    input  wire logic        aclk,
    input  wire logic        aresetn,
    // AXI4-Lite write address
    input  wire logic [7:0]  s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    // AXI4-Lite write data
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    // AXI4-Lite write response
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    // AXI4-Lite read address
    input  wire logic [7:0]  s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    // AXI4-Lite read data
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready,
    // System state
    input  wire logic        hw_start_opt,
    input  wire logic        low_power,
    input  wire logic        debug_halt,
    // Outputs
    output logic             device_reset,
    output logic             irq
);
    // Write channel holding registers
    logic [7:0]  aw_addr_reg;
    logic        aw_full_reg;
    logic [31:0] w_data_reg;
    logic [3:0]  w_strb_reg;
    logic        w_full_reg;
    logic        wr_go;
    logic        wr_hit;

    // Software-visible state
    logic [7:0]  iw_presc_reg;
    logic [11:0] iw_reload_reg;
    logic        iw_timer_reg;
    logic [6:0]  ww_win_reg;
    logic        ww_freeze_reg;
    logic [1:0]  irq_status_reg;
    logic [1:0]  irq_mask_reg;

    // Tick dividers
    logic [$clog2(LSI_DIV)-1:0]  lsi_cnt_reg;
    logic [$clog2(WWDG_DIV)-1:0] ww_pre_reg;
    logic                        lsi_tick;
    logic                        ww_tick;

    // Watchdog hookups
    logic        iw_start;
    logic        iw_reload;
    logic [11:0] iw_count;
    logic        iw_running;
    logic        iw_expire;
    logic        ww_activate;
    logic        ww_write;
    logic [6:0]  ww_count;
    logic        ww_active;
    logic        ww_early;
    logic        ww_reset;
    logic [1:0]  irq_set;
    logic [31:0] rd_word;
    logic        rd_hit;

    // Address and data are taken in either order and held until the response
    assign s_axi_awready = !aw_full_reg;
    assign s_axi_wready  = !w_full_reg;
    assign wr_go         = aw_full_reg && w_full_reg && !s_axi_bvalid;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_full_reg <= 1'b0;
            aw_addr_reg <= 8'h00;
        end else if (s_axi_awvalid && s_axi_awready) begin
            aw_full_reg <= 1'b1;
            aw_addr_reg <= s_axi_awaddr;
        end else if (wr_go) begin
            aw_full_reg <= 1'b0;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            w_full_reg <= 1'b0;
            w_data_reg <= 32'h0000_0000;
            w_strb_reg <= 4'h0;
        end else if (s_axi_wvalid && s_axi_wready) begin
            w_full_reg <= 1'b1;
            w_data_reg <= s_axi_wdata;
            w_strb_reg <= s_axi_wstrb;
        end else if (wr_go) begin
            w_full_reg <= 1'b0;
        end
    end

    always_comb begin
        case (aw_addr_reg)
            `OFS_IW_KEY, `OFS_IW_PRESC, `OFS_IW_RELOAD, `OFS_IW_STATUS, `OFS_IW_CFG,
            `OFS_WW_CTRL, `OFS_WW_CFG, `OFS_IRQ_STATUS, `OFS_IRQ_MASK: wr_hit = 1'b1;
            default: wr_hit = 1'b0;
        endcase
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp  <= RESP_OKAY;
        end else if (wr_go) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= wr_hit ? RESP_OKAY : RESP_DECERR;
        end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
        end
    end

    // Key codes only count when both low lanes are written
    assign iw_reload = wr_go && (aw_addr_reg == `OFS_IW_KEY) && (&w_strb_reg[1:0])
                       && (w_data_reg[15:0] == `KEY_RELOAD);
    assign iw_start  = wr_go && (aw_addr_reg == `OFS_IW_KEY) && (&w_strb_reg[1:0])
                       && (w_data_reg[15:0] == `KEY_START);
    assign ww_write  = wr_go && (aw_addr_reg == `OFS_WW_CTRL) && w_strb_reg[0];
    assign ww_activate = ww_write && w_data_reg[`WW_ACT_BIT];

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            iw_presc_reg  <= `RST_IW_PRESC;
            iw_reload_reg <= `RST_IW_RELOAD;
            iw_timer_reg  <= 1'b0;
            ww_win_reg    <= `RST_WW_WIN;
            ww_freeze_reg <= 1'b0;
            irq_mask_reg  <= 2'h0;
        end else if (wr_go) begin
            case (aw_addr_reg)
                `OFS_IW_PRESC: begin
                    if (w_strb_reg[0]) begin
                        iw_presc_reg <= w_data_reg[7:0];
                    end
                end
                `OFS_IW_RELOAD: begin
                    if (w_strb_reg[0]) begin
                        iw_reload_reg[7:0] <= w_data_reg[7:0];
                    end
                    if (w_strb_reg[1]) begin
                        iw_reload_reg[11:8] <= w_data_reg[11:8];
                    end
                end
                `OFS_IW_CFG: begin
                    if (w_strb_reg[0]) begin
                        iw_timer_reg <= w_data_reg[`IW_TIMER_BIT]; // RULE5
                    end
                end
                `OFS_WW_CFG: begin
                    if (w_strb_reg[0]) begin
                        ww_win_reg <= w_data_reg[6:0];
                    end
                    if (w_strb_reg[1]) begin
                        ww_freeze_reg <= w_data_reg[`WW_FREEZE_BIT]; // RULE11
                    end
                end
                `OFS_IRQ_MASK: begin
                    if (w_strb_reg[0]) begin
                        irq_mask_reg <= w_data_reg[1:0];
                    end
                end
                default: begin
                end
            endcase
        end
    end

    // Low-speed tick stands in for the separate oscillator; it ignores low_power
    assign lsi_tick = (lsi_cnt_reg == ($clog2(LSI_DIV))'(LSI_DIV - 1));

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            lsi_cnt_reg <= '0;
        end else begin
            lsi_cnt_reg <= lsi_tick ? '0 : lsi_cnt_reg + 1'b1; // RULE2 RULE3
        end
    end

    // Window prescaler sits on the main clock, which low-power modes stop
    assign ww_tick = !low_power && (ww_pre_reg == ($clog2(WWDG_DIV))'(WWDG_DIV - 1));

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ww_pre_reg <= '0;
        end else if (!low_power && !(debug_halt && ww_freeze_reg)) begin
            ww_pre_reg <= ww_pre_reg + 1'b1; // RULE9
        end
    end

    indep_wdog #(
        .CNT_W (12),
        .PRE_W (8)
    ) u_indep (
        .aclk       (aclk),
        .aresetn    (aresetn),
        .lsi_tick   (lsi_tick),
        .hw_start   (hw_start_opt),
        .start_cmd  (iw_start),
        .reload_cmd (iw_reload),
        .presc      (iw_presc_reg),
        .reload_val (iw_reload_reg),
        .count      (iw_count),
        .running    (iw_running),
        .expire     (iw_expire)
    );

    window_wdog #(
        .CNT_W (7)
    ) u_window (
        .aclk      (aclk),
        .aresetn   (aresetn),
        .tick      (ww_tick),
        .freeze    (debug_halt && ww_freeze_reg),
        .activate  (ww_activate),
        .write_cnt (ww_write),
        .wr_val    (w_data_reg[6:0]),
        .window    (ww_win_reg),
        .count     (ww_count),
        .active    (ww_active),
        .early     (ww_early),
        .reset_req (ww_reset)
    );

    // Timer mode turns expiry into an interrupt instead of a reset
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            device_reset <= 1'b0;
        end else begin
            device_reset <= (iw_expire && !iw_timer_reg) || ww_reset; // RULE4 RULE12 RULE8
        end
    end

    assign irq_set[`IRQ_IW_BIT] = iw_expire && iw_timer_reg; // RULE5
    assign irq_set[`IRQ_WW_BIT] = ww_early; // RULE10

    // Set wins over a write-one-to-clear in the same cycle
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            irq_status_reg <= 2'h0;
        end else if (wr_go && (aw_addr_reg == `OFS_IRQ_STATUS) && w_strb_reg[0]) begin
            irq_status_reg <= (irq_status_reg & ~w_data_reg[1:0]) | irq_set;
        end else begin
            irq_status_reg <= irq_status_reg | irq_set;
        end
    end

    assign irq = |(irq_status_reg & irq_mask_reg);

    // Read side: one read at a time, answered the cycle after the address
    assign s_axi_arready = !s_axi_rvalid;

    always_comb begin
        rd_hit  = 1'b1;
        rd_word = 32'h0000_0000;
        case (s_axi_araddr)
            `OFS_IW_KEY:     rd_word = 32'h0000_0000;
            `OFS_IW_PRESC:   rd_word = {24'h0, iw_presc_reg};
            `OFS_IW_RELOAD:  rd_word = {20'h0, iw_reload_reg};
            `OFS_IW_STATUS:  rd_word = {15'h0, iw_running, 4'h0, iw_count};
            `OFS_IW_CFG:     rd_word = {31'h0, iw_timer_reg};
            `OFS_WW_CTRL:    rd_word = {24'h0, ww_active, ww_count};
            `OFS_WW_CFG:     rd_word = {23'h0, ww_freeze_reg, 1'b0, ww_win_reg};
            `OFS_IRQ_STATUS: rd_word = {30'h0, irq_status_reg};
            `OFS_IRQ_MASK:   rd_word = {30'h0, irq_mask_reg};
            default:         rd_hit  = 1'b0;
        endcase
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata  <= 32'h0000_0000;
            s_axi_rresp  <= RESP_OKAY;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata  <= rd_word;
            s_axi_rresp  <= rd_hit ? RESP_OKAY : RESP_DECERR;
        end else if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end
endmodule
`default_nettype wire

// file: test/dual_watchdog_timers_sva.sv
// Port-level checks of the watchdog pair: bus handshakes and reset outputs
`timescale 1ns/1ps
`default_nettype none
module dual_watchdog_timers_sva (
    // Clock and reset
    input wire logic        aclk,
    input wire logic        aresetn,
    // Register bus
    input wire logic        s_axi_awvalid,
    input wire logic        s_axi_awready,
    input wire logic        s_axi_wvalid,
    input wire logic        s_axi_wready,
    input wire logic [1:0]  s_axi_bresp,
    input wire logic        s_axi_bvalid,
    input wire logic        s_axi_bready,
    input wire logic [7:0]  s_axi_araddr,
    input wire logic        s_axi_arvalid,
    input wire logic        s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic [1:0]  s_axi_rresp,
    input wire logic        s_axi_rvalid,
    input wire logic        s_axi_rready,
    // Outputs
    input wire logic        device_reset,
    input wire logic        irq
);
    default clocking cb @(posedge aclk);
    endclocking
    default disable iff (!aresetn);

    a_bresp_held: assert property (
        s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
        else $error("write response dropped before taken");
    a_rdata_held: assert property (
        s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read data changed before taken");
    a_read_latency: assert property (
        s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read answer late");
    a_write_latency: assert property (
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |-> ##2 s_axi_bvalid)
        else $error("write answer late");
    a_read_decerr: assert property (
        s_axi_arvalid && s_axi_arready && s_axi_araddr > 8'h20
        |=> s_axi_rresp == 2'b11 && s_axi_rdata == 32'h0)
        else $error("unmapped read not refused");
    a_read_busy: assert property (s_axi_rvalid |-> !s_axi_arready)
        else $error("read address taken while data pending");
    a_aw_blocked: assert property (s_axi_awvalid && s_axi_awready |=> !s_axi_awready)
        else $error("second write address taken");
    a_reset_pulse: assert property (
        device_reset |=> !device_reset)
        else $error("device reset longer than one cycle");
    a_reset_quiet: assert property (
        $rose(aresetn) |-> !device_reset && !irq && !s_axi_bvalid && !s_axi_rvalid)
        else $error("outputs active after reset");

    c_reset: cover property (device_reset);
    c_irq: cover property ($rose(irq));
    c_decerr: cover property (s_axi_rvalid && s_axi_rresp == 2'b11);
endmodule
`default_nettype wire

// file: test/tb.sv
// Self-checking bench for the watchdog pair
`timescale 1ns/1ps
`default_nettype none
`include "wdog_map.svh"
module tb;
    // Short divider keeps every count within a few thousand cycles
    localparam int DIV = 4;
    typedef struct packed {
        logic        wr;
        logic [7:0]  a;
        logic [31:0] d;
        logic [3:0]  s;
        logic [31:0] x;
        logic [1:0]  r;
    } row_t;
    logic        aclk = 1'b0;
    logic        aresetn = 1'b0;
    logic [7:0]  s_axi_awaddr = 8'h00;
    logic        s_axi_awvalid = 1'b0;
    logic        s_axi_awready;
    logic [31:0] s_axi_wdata = 32'h0;
    logic [3:0]  s_axi_wstrb = 4'hF;
    logic        s_axi_wvalid = 1'b0;
    logic        s_axi_wready;
    logic [1:0]  s_axi_bresp;
    logic        s_axi_bvalid;
    logic        s_axi_bready = 1'b0;
    logic [7:0]  s_axi_araddr = 8'h00;
    logic        s_axi_arvalid = 1'b0;
    logic        s_axi_arready;
    logic [31:0] s_axi_rdata;
    logic [1:0]  s_axi_rresp;
    logic        s_axi_rvalid;
    logic        s_axi_rready = 1'b0;
    logic        hw_start_opt = 1'b0;
    logic        low_power = 1'b0;
    logic        debug_halt = 1'b0;
    logic        device_reset;
    logic        irq;
    int          errors = 0;
    int          n_tests = 0;
    int          n_rst = 0;
    int          k;
    logic [31:0] rdat;
    logic [1:0]  resp;
    row_t        rows [0:14] = '{
        '{1'b0, `OFS_IRQ_STATUS, 32'h0, 4'hF, 32'h0, 2'b00},
        '{1'b0, `OFS_IRQ_MASK, 32'h0, 4'hF, 32'h0, 2'b00},
        '{1'b0, `OFS_IW_KEY, 32'h0, 4'hF, 32'h0, 2'b00},
        '{1'b0, `OFS_IW_PRESC, 32'h0, 4'hF, 32'h0, 2'b00},
        '{1'b0, `OFS_IW_RELOAD, 32'h0, 4'hF, 32'hFFF, 2'b00},
        '{1'b0, `OFS_IW_STATUS, 32'h0, 4'hF, 32'hFFF, 2'b00},
        '{1'b0, `OFS_IW_CFG, 32'h0, 4'hF, 32'h0, 2'b00},
        '{1'b0, `OFS_WW_CFG, 32'h0, 4'hF, 32'h7F, 2'b00},
        '{1'b1, 8'h24, 32'h1, 4'hF, 32'h0, 2'b11},
        '{1'b1, `OFS_IW_PRESC, 32'hFFFFFFFF, 4'hE, 32'h0, 2'b00},
        '{1'b1, `OFS_IW_PRESC, 32'hFFFFFFFF, 4'hF, 32'hFF, 2'b00},
        '{1'b1, `OFS_IW_RELOAD, 32'hFFFFFFFF, 4'hF, 32'hFFF, 2'b00},
        '{1'b1, `OFS_IW_CFG, 32'hFFFFFFFF, 4'hF, 32'h1, 2'b00},
        '{1'b1, `OFS_WW_CFG, 32'hFFFFFFFF, 4'hF, 32'h17F, 2'b00},
        '{1'b1, `OFS_IRQ_MASK, 32'hFFFFFFFF, 4'hF, 32'h3, 2'b00}};

    dual_watchdog_timers #(.LSI_DIV(DIV), .WWDG_DIV(DIV)) dut (
        .aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
        .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
        .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
        .s_axi_rready, .hw_start_opt, .low_power, .debug_halt, .device_reset, .irq);

    initial begin
        forever #10 aclk = ~aclk;
    end

    always @(posedge aclk) begin
        if (device_reset === 1'b1)
            n_rst <= n_rst + 1;
    end

    task automatic test_done;
        if (errors == 0 && n_tests > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask

    task automatic hang;
        errors++;
        test_done();
    endtask

    task automatic check(input string name, input logic [31:0] exp, input logic [31:0] got);
        n_tests++;
        if (got !== exp) begin
            errors++;
            $display("MISMATCH %s expected %h seen %h", name, exp, got);
        end
    endtask

    // Ready is released one edge after the answer so no signal is driven twice in one step
    task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s,
                          output logic [1:0] r);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_wstrb <= s;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        for (k = 0; k < 100; k++) begin
            @(posedge aclk);
            if (s_axi_awvalid && s_axi_awready)
                s_axi_awvalid <= 1'b0;
            if (s_axi_wvalid && s_axi_wready)
                s_axi_wvalid <= 1'b0;
            if (s_axi_bvalid === 1'b1)
                break;
        end
        r = s_axi_bresp;
        s_axi_bready <= 1'b0;
        if (k == 100)
            hang();
        @(posedge aclk);
    endtask

    task automatic axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        for (k = 0; k < 100; k++) begin
            @(posedge aclk);
            if (s_axi_arvalid && s_axi_arready)
                s_axi_arvalid <= 1'b0;
            if (s_axi_rvalid === 1'b1)
                break;
        end
        d = s_axi_rdata;
        r = s_axi_rresp;
        s_axi_rready <= 1'b0;
        if (k == 100)
            hang();
        @(posedge aclk);
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        axi_wr(a, d, 4'hF, resp);
        check("bresp", 32'h0, {30'h0, resp});
    endtask

    task automatic rd(input string name, input logic [7:0] a, input logic [31:0] x);
        axi_rd(a, rdat, resp);
        check("rresp", 32'h0, {30'h0, resp});
        check(name, x, rdat);
    endtask

    // Leaves the number of cycles waited in k
    task automatic wait_sig(input int lim, input logic rst_sel);
        for (k = 0; k < lim; k++) begin
            @(posedge aclk);
            if (rst_sel ? device_reset === 1'b1 : irq === 1'b1)
                break;
        end
        if (k == lim)
            hang();
    endtask

    initial begin
        repeat (12) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        foreach (rows[i]) begin
            if (rows[i].wr) begin
                axi_wr(rows[i].a, rows[i].d, rows[i].s, resp);
                check("bresp", {30'h0, rows[i].r}, {30'h0, resp});
            end
            axi_rd(rows[i].a, rdat, resp);
            check("rresp", {30'h0, rows[i].r}, {30'h0, resp});
            check("rdata", rows[i].x, rdat);
        end
        // Inactive window counter wraps freely, so an early warning arrives unasked
        wait_sig(400, 1'b0);
        rd("irq_status", `OFS_IRQ_STATUS, 32'h2);
        wr(`OFS_IRQ_MASK, 32'h1);
        check("irq_masked", 32'h0, {31'h0, irq});
        wr(`OFS_IRQ_STATUS, 32'h2);
        rd("irq_cleared", `OFS_IRQ_STATUS, 32'h0);
        debug_halt <= 1'b1;
        wr(`OFS_WW_CTRL, 32'h50);
        repeat (40) @(posedge aclk);
        rd("ww_frozen", `OFS_WW_CTRL, 32'h50);
        debug_halt <= 1'b0;
        low_power <= 1'b1;
        repeat (40) @(posedge aclk);
        rd("ww_asleep", `OFS_WW_CTRL, 32'h50);
        wr(`OFS_IW_PRESC, 32'h0);
        wr(`OFS_IW_RELOAD, 32'h3);
        wr(`OFS_IW_KEY, {16'h0, `KEY_START});
        axi_rd(`OFS_IW_STATUS, rdat, resp);
        check("iw_started", 32'h1, {31'h0, rdat[16]});
        wait_sig(200, 1'b0);
        rd("iw_timeout", `OFS_IRQ_STATUS, 32'h1);
        low_power <= 1'b0;
        repeat (40) @(posedge aclk);
        axi_rd(`OFS_WW_CTRL, rdat, resp);
        check("ww_resumed", 32'h1, {31'h0, rdat[6:0] < 7'h50});
        wr(`OFS_IW_PRESC, 32'hFF);
        wr(`OFS_IW_KEY, {16'h0, `KEY_RELOAD});
        wr(`OFS_IW_CFG, 32'h0);
        wait_sig(5000, 1'b1);
        check("iw_period", 32'h1, {31'h0, k >= 4083 && k <= 4088});
        repeat (2) @(posedge aclk);
        check("reset_pulses", 32'h1, n_rst);
        aresetn <= 1'b0;
        hw_start_opt <= 1'b1;
        repeat (12) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        axi_rd(`OFS_IW_STATUS, rdat, resp);
        check("iw_autostart", 32'h1, {31'h0, rdat[16]});
        wr(`OFS_WW_CTRL, 32'hFF);
        wait_sig(400, 1'b1);
        check("ww_reset_time", 32'h1, {31'h0, k >= 251 && k <= 256});
        wr(`OFS_WW_CFG, 32'h30);
        wr(`OFS_WW_CTRL, 32'hFF);
        @(posedge aclk);
        check("ww_too_early", 32'h3, n_rst);
        test_done();
    end
endmodule

bind dual_watchdog_timers dual_watchdog_timers_sva u_sva (
    .aclk, .aresetn, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
    .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .device_reset, .irq);
`default_nettype wire
